// ===== src/awctl_map.svh
`ifndef AWCTL_MAP_SVH
`define AWCTL_MAP_SVH

// Full address byte: seven-bit address plus write direction bit
`define AWCTL_DEV_ADDR 8'hf8

// Select codes carried in the upper three bits of the data byte
`define AWCTL_SEL_GENERAL 3'h1
`define AWCTL_SEL_ROUTING 3'h2
// Routing needs six field bits, so it answers to both codes with upper bits 01
`define AWCTL_SEL_ROUTING_HI 3'h3
`define AWCTL_SEL_GAIN 3'h4
`define AWCTL_SEL_DIFF_VOL 3'h5
`define AWCTL_SEL_LEFT_VOL 3'h6
`define AWCTL_SEL_RIGHT_VOL 3'h7
`define AWCTL_SEL_MSB 7
`define AWCTL_SEL_LSB 5

// Field positions
`define AWCTL_GEN_POWER 0
`define AWCTL_GEN_FAST 1
`define AWCTL_GEN_BIAS 2
`define AWCTL_GEN_GSTAGE 3
`define AWCTL_RT_MODE_MSB 3
`define AWCTL_RT_HPR 4
`define AWCTL_RT_PASS 5
`define AWCTL_GN_HP_MSB 2
`define AWCTL_GN_SPK 3
`define AWCTL_GN_MUTE 4
`define AWCTL_VOL_MSB 4

`define AWCTL_REG_RESET 8'h00

// Wake-up times in ms, and the system clock in kHz
`define AWCTL_WAKE_NORMAL_MS 30
`define AWCTL_WAKE_FAST_MS 15
`define AWCTL_CLK_KHZ 25000
`define AWCTL_MAX_SCL_KHZ 400

`endif

// ===== src/awctl_pkg.sv
package awctl_pkg;
   typedef enum logic [1:0] {
      awctl_idle,
      awctl_addr,
      awctl_data,
      awctl_skip
   } awctl_phase_type;

   typedef struct packed {
      logic [7:0] general;
      logic [7:0] routing;
      logic [7:0] gain;
      logic [7:0] diff_vol;
      logic [7:0] left_vol;
      logic [7:0] right_vol;
   } awctl_regs_type;
endpackage : awctl_pkg

// ===== src/awctl_wr_if.sv
`timescale 1ns/1ps
// Carries a received data byte from the link domain to the system domain
interface awctl_wr_if;
   logic toggle;
   logic [7:0] data;
   modport link (output toggle, output data);
   modport sys (input toggle, input data);
endinterface : awctl_wr_if

// ===== src/awctl_link.sv
`timescale 1ns/1ps
`include "awctl_map.svh"
// Link-side receiver, clocked by the bus clock (sampling on its rising edge)
// no internal bit timing
// Any bus clock up to 400kHz works since the bus clock itself steps the logic
module awctl_link
   import awctl_pkg::*;
(
   input wire logic scl,
   input wire logic srst_link,
   input wire logic sda_in,
   output logic sda_oe_n,
   awctl_wr_if.link wr
);
   awctl_phase_type phase;
   logic [3:0] count;
   logic [7:0] shift;
   logic ack_slot;
   logic addr_ok;
   logic [7:0] next_shift;
   logic ack_drive;
   logic start_tgl;
   logic start_seen;
   logic start_sync;

   assign next_shift = {shift[6:0], sda_in};

   // start detect, falling data while clock high
   always_ff @(negedge sda_in or posedge srst_link) begin
      if (srst_link) begin
         start_tgl <= 1'b0;
      end else if (scl) begin
         start_tgl <= ~start_tgl;
      end
   end

   always_ff @(posedge scl) begin
      start_sync <= start_tgl;
   end
   assign start_seen = start_sync ^ start_tgl;

   always_ff @(posedge scl) begin
      if (srst_link) begin
         phase <= awctl_idle;
         count <= 4'h0;
         shift <= 8'h00;
         ack_slot <= 1'b0;
         addr_ok <= 1'b0;
         wr.toggle <= 1'b0;
         wr.data <= 8'h00;
      end else if (start_seen) begin
         phase <= awctl_addr;
         count <= 4'h1;
         shift <= {7'h00, sda_in};
         ack_slot <= 1'b0;
      end else begin
         unique case (phase)
            awctl_idle, awctl_skip: begin
               count <= 4'h0;
            end
            awctl_addr, awctl_data: begin
               if (ack_slot) begin
                  ack_slot <= 1'b0;
                  count <= 4'h0;
                  phase <= (phase == awctl_addr && addr_ok) ? awctl_data : awctl_skip;
               end else if (count == 4'h7) begin
                  count <= 4'h8;
                  ack_slot <= 1'b1;
                  shift <= next_shift;
                  if (phase == awctl_addr) begin
                     addr_ok <= (next_shift == `AWCTL_DEV_ADDR);
                  end else begin
                     wr.data <= next_shift;
                     wr.toggle <= ~wr.toggle;
                  end
               end else begin
                  count <= count + 4'h1;
                  shift <= next_shift;
               end
            end
         endcase
      end
   end

   // acknowledge drive
   // Ack driven through the ninth low and high phase
   assign ack_drive = ack_slot && (phase == awctl_data || addr_ok);
   always_ff @(negedge scl) begin
      if (srst_link) begin
         sda_oe_n <= 1'b1;
      end else begin
         sda_oe_n <= ~ack_drive;
      end
   end
endmodule : awctl_link

// ===== src/awctl_top.sv
`timescale 1ns/1ps
`include "awctl_map.svh"
//
// Contract
// - Slave only, never drives clock
// - Works with bus clock up to 400kHz
// - Data stable while clock high
// - Eight bits then one acknowledge slot
// - Recognise address byte 11111000 only
// - Falling data, clock high, is start
// - Read direction not acknowledged
// - Bits sampled on rising clock
// - Matching address acknowledged on ninth pulse
// - One data byte, acknowledged after
// - All bits zero at power-up
// - General control holds four controls
// - Routing register holds mode, disable, bypass
// - Gain register holds speaker, headphone gains
// - Mute bit silences non-bypass inputs
// - Three five-bit volume registers
// - Ready after 30 or 15 ms
// - Hard reset clears mode, volumes, power
// - Writes accepted regardless of power
// - Power enable gates whole device; code gates only device_enable, device_ready
module awctl_top #(
   parameter int unsigned wake_normal_cycles = `AWCTL_WAKE_NORMAL_MS * `AWCTL_CLK_KHZ,
   parameter int unsigned wake_fast_cycles = `AWCTL_WAKE_FAST_MS * `AWCTL_CLK_KHZ
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic hard_reset_n,
   output logic device_enable,
   output logic device_ready,
   output logic fast_turn_on,
   output logic speaker_bias_reduce,
   output logic unused_gain_stage_off,
   output logic [3:0] output_mode,
   output logic right_headphone_off,
   output logic earpiece_passthrough,
   output logic [2:0] headphone_attenuation,
   output logic speaker_boost,
   output logic input_mute,
   output logic [4:0] differential_volume,
   output logic [4:0] left_volume,
   output logic [4:0] right_volume
);
   import awctl_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Link domain
   awctl_wr_if wr ();
   logic link_sda_oe_n;
   logic [1:0] link_rst_sync;

   // Reset reaches the link domain through two flops on the bus clock
   always_ff @(posedge scl) begin
      link_rst_sync <= {link_rst_sync[0], srst};
   end

   // slave only
   // The module has no clock output; data is open-drain, low only
   awctl_link u_link (
      .scl(scl),
      .srst_link(link_rst_sync[1]),
      .sda_in(sda_in),
      .sda_oe_n(link_sda_oe_n),
      .wr(wr)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Crossing into the system domain
   logic [2:0] tgl_sync;
   logic [1:0] hrst_sync;
   logic [1:0] oe_sync;
   logic write_pulse;
   logic [7:0] byte_hold;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         tgl_sync <= 3'h0;
         hrst_sync <= 2'h3;
         oe_sync <= 2'h3;
         byte_hold <= 8'h00;
      end else begin
         tgl_sync <= {tgl_sync[1:0], wr.toggle};
         hrst_sync <= {hrst_sync[0], hard_reset_n};
         oe_sync <= {oe_sync[0], link_sda_oe_n};
         byte_hold <= wr.data;
      end
   end
   // Data is stable long before the toggle settles through two flops
   assign write_pulse = tgl_sync[2] ^ tgl_sync[1];

   ////////////////////////////////////////////////////////////////////////////
   // Register file
   awctl_regs_type regs;
   awctl_regs_type next_regs;
   logic hrst_active;

   assign hrst_active = ~hrst_sync[1];

   always_comb begin
      next_regs = regs;
      if (write_pulse) begin
         unique case (byte_hold[`AWCTL_SEL_MSB:`AWCTL_SEL_LSB])
            `AWCTL_SEL_GENERAL: next_regs.general = {4'h0, byte_hold[3:0]};
            `AWCTL_SEL_ROUTING, `AWCTL_SEL_ROUTING_HI: begin
               next_regs.routing = {2'h0, byte_hold[5:0]};
            end
            `AWCTL_SEL_GAIN: next_regs.gain = {3'h0, byte_hold[4:0]};
            `AWCTL_SEL_DIFF_VOL: next_regs.diff_vol = {3'h0, byte_hold[4:0]};
            `AWCTL_SEL_LEFT_VOL: next_regs.left_vol = {3'h0, byte_hold[4:0]};
            `AWCTL_SEL_RIGHT_VOL: next_regs.right_vol = {3'h0, byte_hold[4:0]};
            default: next_regs = regs;
         endcase
      end
      if (hrst_active) begin
         next_regs.general[`AWCTL_GEN_POWER] = 1'b0;
         next_regs.routing[`AWCTL_RT_MODE_MSB:0] = 4'h0;
         next_regs.diff_vol = `AWCTL_REG_RESET;
         next_regs.left_vol = `AWCTL_REG_RESET;
         next_regs.right_vol = `AWCTL_REG_RESET;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         regs <= '0;
      end else begin
         regs <= next_regs;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wake-up timer
   logic [31:0] wake_count;
   logic [31:0] wake_target;
   logic power_on;

   assign power_on = regs.general[`AWCTL_GEN_POWER] & ~hrst_active;
   assign wake_target = regs.general[`AWCTL_GEN_FAST] ? wake_fast_cycles : wake_normal_cycles;

   always_ff @(posedge sys_clk) begin
      if (srst || !power_on) begin
         wake_count <= 32'h0;
      end else if (wake_count < wake_target) begin
         wake_count <= wake_count + 32'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sda_out <= 1'b0;
         sda_oe_n <= 1'b1;
         device_enable <= 1'b0;
         device_ready <= 1'b0;
         fast_turn_on <= 1'b0;
         speaker_bias_reduce <= 1'b0;
         unused_gain_stage_off <= 1'b0;
         output_mode <= 4'h0;
         right_headphone_off <= 1'b0;
         earpiece_passthrough <= 1'b0;
         headphone_attenuation <= 3'h0;
         speaker_boost <= 1'b0;
         input_mute <= 1'b0;
         differential_volume <= 5'h00;
         left_volume <= 5'h00;
         right_volume <= 5'h00;
      end else begin
         sda_out <= 1'b0;
         sda_oe_n <= oe_sync[1];
         device_enable <= power_on;
         device_ready <= power_on && (wake_count >= wake_target);
         fast_turn_on <= regs.general[`AWCTL_GEN_FAST];
         speaker_bias_reduce <= regs.general[`AWCTL_GEN_BIAS];
         unused_gain_stage_off <= regs.general[`AWCTL_GEN_GSTAGE];
         output_mode <= regs.routing[`AWCTL_RT_MODE_MSB:0];
         right_headphone_off <= regs.routing[`AWCTL_RT_HPR];
         earpiece_passthrough <= regs.routing[`AWCTL_RT_PASS];
         headphone_attenuation <= regs.gain[`AWCTL_GN_HP_MSB:0];
         speaker_boost <= regs.gain[`AWCTL_GN_SPK];
         input_mute <= regs.gain[`AWCTL_GN_MUTE];
         differential_volume <= regs.diff_vol[`AWCTL_VOL_MSB:0];
         left_volume <= regs.left_vol[`AWCTL_VOL_MSB:0];
         right_volume <= regs.right_vol[`AWCTL_VOL_MSB:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   // clear after reset
   reset_clear_a: assert property (@(posedge sys_clk) $fell(srst) |-> regs == '0)
      else $error("registers not zero after reset");
   hard_clear_a: assert property (@(posedge sys_clk) disable iff (srst)
      hrst_active |=> regs.general[0] == 1'b0 && regs.diff_vol == 8'h00)
      else $error("hard reset did not clear");
   power_gate_a: assert property (@(posedge sys_clk) disable iff (srst)
      !power_on |=> !device_enable && !device_ready)
      else $error("enabled while power off");
   wake_wait_a: assert property (@(posedge sys_clk) disable iff (srst)
      $rose(power_on) |=> !device_ready [*2])
      else $error("ready too early");
   write_take_a: assert property (@(posedge sys_clk) disable iff (srst || hrst_active)
      write_pulse && byte_hold[7:5] == `AWCTL_SEL_GAIN |=> regs.gain[4:0] == $past(byte_hold[4:0]))
      else $error("gain write lost");
   no_stray_a: assert property (@(posedge sys_clk) disable iff (srst || hrst_active)
      !write_pulse |=> regs == $past(regs))
      else $error("register changed without write");
   vol_out_a: assert property (@(posedge sys_clk) disable iff (srst)
      ##1 left_volume == $past(regs.left_vol[4:0]))
      else $error("left volume output mismatch");
   ack_mirror_a: assert property (@(posedge sys_clk) disable iff (srst)
      ##1 sda_oe_n == $past(oe_sync[1]))
      else $error("ack enable mismatch");
   fast_out_a: assert property (@(posedge sys_clk) disable iff (srst)
      ##1 fast_turn_on == $past(regs.general[1]))
      else $error("fast turn-on output mismatch");
   bias_out_a: assert property (@(posedge sys_clk) disable iff (srst)
      ##1 speaker_bias_reduce == $past(regs.general[2]))
      else $error("bias output mismatch");
   gstage_out_a: assert property (@(posedge sys_clk) disable iff (srst)
      ##1 unused_gain_stage_off == $past(regs.general[3]))
      else $error("gain stage output mismatch");
   mode_out_a: assert property (@(posedge sys_clk) disable iff (srst)
      ##1 output_mode == $past(regs.routing[3:0]))
      else $error("mode output mismatch");
   hpr_out_a: assert property (@(posedge sys_clk) disable iff (srst)
      ##1 right_headphone_off == $past(regs.routing[4]))
      else $error("right headphone output mismatch");
   pass_out_a: assert property (@(posedge sys_clk) disable iff (srst)
      ##1 earpiece_passthrough == $past(regs.routing[5]))
      else $error("bypass output mismatch");
   hp_att_out_a: assert property (@(posedge sys_clk) disable iff (srst)
      ##1 headphone_attenuation == $past(regs.gain[2:0]))
      else $error("headphone gain output mismatch");
   boost_out_a: assert property (@(posedge sys_clk) disable iff (srst)
      ##1 speaker_boost == $past(regs.gain[3]))
      else $error("speaker gain output mismatch");
   mute_out_a: assert property (@(posedge sys_clk) disable iff (srst)
      ##1 input_mute == $past(regs.gain[4]))
      else $error("mute output mismatch");
   diff_out_a: assert property (@(posedge sys_clk) disable iff (srst)
      ##1 differential_volume == $past(regs.diff_vol[4:0]))
      else $error("differential volume output mismatch");
   right_out_a: assert property (@(posedge sys_clk) disable iff (srst)
      ##1 right_volume == $past(regs.right_vol[4:0]))
      else $error("right volume output mismatch");
   general_take_a: assert property (@(posedge sys_clk) disable iff (srst || hrst_active)
      write_pulse && byte_hold[7:5] == 3'h1 |=> regs.general == {4'h0, $past(byte_hold[3:0])})
      else $error("general write lost");
   routing_take_a: assert property (@(posedge sys_clk) disable iff (srst || hrst_active)
      write_pulse && byte_hold[7:6] == 2'h1 |=> regs.routing == {2'h0, $past(byte_hold[5:0])})
      else $error("routing write lost");
   diff_take_a: assert property (@(posedge sys_clk) disable iff (srst || hrst_active)
      write_pulse && byte_hold[7:5] == 3'h5 |=> regs.diff_vol == {3'h0, $past(byte_hold[4:0])})
      else $error("differential volume write lost");
   left_take_a: assert property (@(posedge sys_clk) disable iff (srst || hrst_active)
      write_pulse && byte_hold[7:5] == 3'h6 |=> regs.left_vol == {3'h0, $past(byte_hold[4:0])})
      else $error("left volume write lost");
   right_take_a: assert property (@(posedge sys_clk) disable iff (srst || hrst_active)
      write_pulse && byte_hold[7:5] == 3'h7 |=> regs.right_vol == {3'h0, $past(byte_hold[4:0])})
      else $error("right volume write lost");
   spare_sel_a: assert property (@(posedge sys_clk) disable iff (srst || hrst_active)
      write_pulse && byte_hold[7:5] == 3'h0 |=> regs == $past(regs))
      else $error("spare select changed a register");
   upper_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
      regs.general[7:4] == 4'h0 && regs.routing[7:6] == 2'h0 && regs.gain[7:5] == 3'h0)
      else $error("unused register bits set");
   hard_route_a: assert property (@(posedge sys_clk) disable iff (srst)
      hrst_active |=> regs.routing[3:0] == 4'h0 && regs.left_vol == 8'h00 && regs.right_vol == 8'h00)
      else $error("hard reset left mode or volume");
   hard_keep_a: assert property (@(posedge sys_clk) disable iff (srst)
      hrst_active && !write_pulse |=> regs.gain == $past(regs.gain)
      && regs.general[3:1] == $past(regs.general[3:1]) && regs.routing[5:4] == $past(regs.routing[5:4]))
      else $error("hard reset changed kept bits");
   hard_off_a: assert property (@(posedge sys_clk) disable iff (srst)
      hrst_active |=> !device_enable)
      else $error("enabled during hard reset");
   sda_low_a: assert property (@(posedge sys_clk) disable iff (srst)
      sda_out == 1'b0)
      else $error("data line driven high");
   enable_follow_a: assert property (@(posedge sys_clk) disable iff (srst)
      ##1 device_enable == $past(power_on))
      else $error("enable does not follow power");
   ready_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
      device_ready && power_on |=> device_ready)
      else $error("ready dropped while powered");
   ready_due_a: assert property (@(posedge sys_clk) disable iff (srst)
      power_on && wake_count >= wake_target |=> device_ready)
      else $error("ready late");
   wake_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
      !power_on |=> wake_count == 32'h0)
      else $error("wake timer not cleared");
endmodule : awctl_top

// ===== test/awctl_master.sv
`timescale 1ns/1ps
// Bus master model: the clock runs inside frames and in idle_clocks, idle bus rests high
module awctl_master #(
   parameter int half_ns = 1250
) (
   output logic scl,
   output logic sda_drv,
   input wire logic sda_wire
);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // data moves only while clock low
   task automatic put_bit(input logic b, output logic seen);
      #(half_ns / 2) sda_drv = b;
      #(half_ns / 2) scl = 1'b1;
      seen = sda_wire;
      #(half_ns) scl = 1'b0;
   endtask : put_bit
   // eight bits MSB first, then line released
   task automatic put_byte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(v[i], s);
      end
      put_bit(1'b1, s);
      ack = ~s;
   endtask : put_byte
   task automatic frame(input logic [7:0] a, input logic [7:0] d, output logic [1:0] ack);
      sda_drv = 1'b0;
      #(half_ns) scl = 1'b0;
      put_byte(a, ack[1]);
      put_byte(d, ack[0]);
      #(half_ns / 2) sda_drv = 1'b0;
      #(half_ns / 2) scl = 1'b1;
      #(half_ns) sda_drv = 1'b1;
      #(half_ns);
   endtask : frame
   task automatic idle_clocks(input int n);
      repeat (n) begin
         #(half_ns) scl = 1'b0;
         #(half_ns) scl = 1'b1;
      end
   endtask : idle_clocks
endmodule : awctl_master

// ===== test/awctl_top_tb.sv
`timescale 1ns/1ps
`include "awctl_map.svh"
module awctl_top_tb;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic hard_reset_n = 1'b1;
   logic scl, sda_drv, sda_out, sda_oe_n, device_enable, device_ready;
   logic fast_turn_on, speaker_bias_reduce, unused_gain_stage_off;
   logic right_headphone_off, earpiece_passthrough, speaker_boost, input_mute;
   logic [3:0] output_mode;
   logic [2:0] headphone_attenuation;
   logic [4:0] differential_volume, left_volume, right_volume;
   wire logic sda_wire;
   int n_errors = 0;
   int checked = 0;
   int up_cnt = 0;
   logic [7:0] e_gen = 8'h00, e_rt = 8'h00, e_gn = 8'h00;
   logic [7:0] e_dv = 8'h00, e_lv = 8'h00, e_rv = 8'h00;

   always #20 sys_clk = ~sys_clk;
   // Open-drain data line with pull-up
   assign sda_wire = sda_drv & (sda_oe_n | sda_out);
   // Cycles from power enable to ready
   always @(posedge sys_clk) begin
      if (device_enable !== 1'b1) up_cnt <= 0;
      else if (device_ready !== 1'b1) up_cnt <= up_cnt + 1;
   end

   awctl_top #(.wake_normal_cycles(200), .wake_fast_cycles(100)) uut (
      .sys_clk(sys_clk), .srst(srst), .scl(scl), .sda_in(sda_wire), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .hard_reset_n(hard_reset_n), .device_enable(device_enable),
      .device_ready(device_ready), .fast_turn_on(fast_turn_on),
      .speaker_bias_reduce(speaker_bias_reduce), .unused_gain_stage_off(unused_gain_stage_off),
      .output_mode(output_mode), .right_headphone_off(right_headphone_off),
      .earpiece_passthrough(earpiece_passthrough),
      .headphone_attenuation(headphone_attenuation), .speaker_boost(speaker_boost),
      .input_mute(input_mute), .differential_volume(differential_volume),
      .left_volume(left_volume), .right_volume(right_volume));
   awctl_master #(.half_ns(1250)) master (.scl(scl), .sda_drv(sda_drv), .sda_wire(sda_wire));

   ////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   task automatic check_all();
      cmp("power", {7'h0, e_gen[0]}, {7'h0, device_enable});
      cmp("sda out", 8'h00, {7'h0, sda_out});
      cmp("general", {5'h0, e_gen[3:1]}, {5'h0, unused_gain_stage_off,
         speaker_bias_reduce, fast_turn_on});
      cmp("routing", {2'h0, e_rt[5:0]}, {2'h0, earpiece_passthrough, right_headphone_off,
         output_mode});
      cmp("gain", {3'h0, e_gn[4:0]}, {3'h0, input_mute, speaker_boost,
         headphone_attenuation});
      cmp("diff", e_dv, {3'h0, differential_volume});
      cmp("left", e_lv, {3'h0, left_volume});
      cmp("right", e_rv, {3'h0, right_volume});
   endtask : check_all

   function automatic void expect_write(input logic [7:0] d);
      case (d[7:5])
         `AWCTL_SEL_GENERAL: e_gen = {4'h0, d[3:0]};
         `AWCTL_SEL_ROUTING, `AWCTL_SEL_ROUTING_HI: e_rt = {2'h0, d[5:0]};
         `AWCTL_SEL_GAIN: e_gn = {3'h0, d[4:0]};
         `AWCTL_SEL_DIFF_VOL: e_dv = {3'h0, d[4:0]};
         `AWCTL_SEL_LEFT_VOL: e_lv = {3'h0, d[4:0]};
         `AWCTL_SEL_RIGHT_VOL: e_rv = {3'h0, d[4:0]};
         default: ;
      endcase
   endfunction : expect_write

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] exp_ack);
      logic [1:0] ack;
      @(posedge sys_clk);
      #7;
      master.frame(a, d, ack);
      cmp("ack", {6'h0, exp_ack}, {6'h0, ack});
      repeat (10) @(posedge sys_clk);
      #1;
   endtask : wr

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      logic [7:0] tbl[7] = '{8'h2e, 8'h5a, 8'h9d, 8'hbf, 8'hc1, 8'hf3, 8'h61};
      for (int i = 0; i < 7; i++) begin
         wr(`AWCTL_DEV_ADDR, tbl[i], 2'b11);
         expect_write(tbl[i]);
         check_all();
      end
   endtask : t_regs

   task automatic t_bad_addr();
      logic [7:0] bad[3] = '{8'hf9, 8'hf0, 8'h78};
      for (int i = 0; i < 3; i++) begin
         wr(bad[i], 8'hff, 2'b00);
         check_all();
      end
   endtask : t_bad_addr

   task automatic t_power();
      int n;
      for (int f = 1; f >= 0; f--) begin
         wr(`AWCTL_DEV_ADDR, {`AWCTL_SEL_GENERAL, 3'h0, f[0], 1'b1}, 2'b11);
         expect_write({`AWCTL_SEL_GENERAL, 3'h0, f[0], 1'b1});
         check_all();
         n = 0;
         while (device_ready !== 1'b1 && n < 400) begin
            @(posedge sys_clk);
            n++;
         end
         #1;
         cmp("ready", 8'h01, {7'h0, device_ready});
         cmp("wake", 8'h01, {7'h0, (up_cnt >= (f ? 92 : 192)) && (up_cnt <= (f ? 108 : 208))});
         wr(`AWCTL_DEV_ADDR, {`AWCTL_SEL_GENERAL, 5'h0}, 2'b11);
         expect_write({`AWCTL_SEL_GENERAL, 5'h0});
         check_all();
         cmp("ready off", 8'h00, {7'h0, device_ready});
      end
   endtask : t_power

   task automatic t_hard();
      wr(`AWCTL_DEV_ADDR, 8'h2f, 2'b11);
      expect_write(8'h2f);
      @(posedge sys_clk) hard_reset_n <= 1'b0;
      repeat (10) @(posedge sys_clk);
      #1;
      e_gen[0] = 1'b0;
      e_rt[3:0] = 4'h0;
      e_dv = 8'h00;
      e_lv = 8'h00;
      e_rv = 8'h00;
      check_all();
      @(posedge sys_clk) hard_reset_n <= 1'b1;
      repeat (5) @(posedge sys_clk);
      #1;
      check_all();
   endtask : t_hard

   task automatic wrap_up();
      if (n_errors == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #3_000_000;
      n_errors++;
      wrap_up();
   end

   initial begin
      repeat (10) @(posedge sys_clk);
      // Link reset needs bus clock edges while held
      master.idle_clocks(3);
      @(posedge sys_clk) srst <= 1'b0;
      master.idle_clocks(3);
      #1;
      check_all();
      cmp("oe", 8'h01, {7'h0, sda_oe_n});
      t_regs();
      t_bad_addr();
      t_power();
      t_hard();
      wrap_up();
   end
endmodule : awctl_top_tb
